// file: lssr_consts.svh
// Offsets, field positions and reset values of the link/slot report registers
`ifndef LSSR_CONSTS_SVH
`define LSSR_CONSTS_SVH
`define LSSR_OFF_LINK          8'hd0
`define LSSR_OFF_SLOT          8'hd4
`define LSSR_SPEED_2G5         4'h1
`define LSSR_SPEED_5G0         4'h2
`define LSSR_WIDTH_RESET       6'h01
`define LSSR_LINK_TRAIN_BIT    27
`define LSSR_PWR_VAL_LSB       7
`define LSSR_PWR_VAL_MSB       14
`define LSSR_PWR_SCL_LSB       15
`define LSSR_PWR_SCL_MSB       16
`define LSSR_BWM_BIT           30
`define LSSR_ABW_BIT           31
`define LSSR_PWR_VAL_RESET     8'h19
`define LSSR_PWR_SCL_RESET     2'h0
`define LSSR_PRESENT_RESET     5'h1f
`define LSSR_SURPRISE_RESET    1'h0
`define LSSR_HP_CAP_RESET      1'h1
`define LSSR_SLOT_CLK_RESET    1'h1
`define LSSR_SLOT_NUM_RESET    13'h0000
`endif

// file: lssr_pkg.sv
// Types shared by the link/slot report register bank
package lssr_pkg;
	typedef enum logic [1:0] {
		lssr_speed_idle,
		lssr_speed_known
	} lssr_spd_state_type;
	typedef logic [31:0] lssr_word_type;
endpackage : lssr_pkg

// file: lssr_regs.sv
// Link status and slot capabilities register bank of one switch port
`timescale 1ns/1ns
`include "lssr_consts.svh"

module lssr_regs
	import lssr_pkg::*;
#(
	parameter bit DOWNSTREAM = 1'b1
) (
	// Clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_rst_n,
	// Configuration access
	input  wire logic        i_cfg_rd,
	input  wire logic        i_cfg_wr,
	input  wire logic [7:0]  i_cfg_addr,
	input  wire logic [3:0]  i_cfg_be,
	input  wire logic [31:0] i_cfg_wdata,
	output logic      [31:0] o_cfg_rdata,
	output logic             o_cfg_ack,
	// Link layer state, port core clock domain
	input  wire logic        i_link_gen2,
	input  wire logic        i_speed_valid,
	input  wire logic [5:0]  i_link_width,
	input  wire logic        i_train_fail,
	input  wire logic        i_train_done,
	input  wire logic        i_train_start,
	input  wire logic        i_dl_active,
	input  wire logic        i_bw_mgmt_event,
	input  wire logic        i_auto_bw_event,
	// Preload agent (serial management or EEPROM loader)
	input  wire logic        i_pre_wr,
	input  wire logic [7:0]  i_pre_addr,
	input  wire logic [31:0] i_pre_data,
	// Slot power limit message request
	output logic             o_spl_msg,
	output logic [7:0]       o_spl_value,
	output logic [1:0]       o_spl_scale
);
	// Reset release
	logic        rst_n;
	// Link status fields
	logic [3:0]  speed;
	logic [5:0]  width;
	logic        train_err;
	logic        training;
	logic        slot_clk;
	logic        dl_act;
	logic        bw_mgmt;
	logic        auto_bw;
	// Slot capability fields
	logic [4:0]  present;
	logic        surprise;
	logic        hp_cap;
	logic [7:0]  pwr_val;
	logic [1:0]  pwr_scl;
	logic [12:0] slot_num;
	// Decode
	logic        wr_link;
	logic        wr_slot;
	logic        pre_link;
	logic        pre_slot;
	logic        pwr_touch;
	logic        bw_clr;
	logic        ab_clr;
	logic [31:0] wr_mask;
	lssr_word_type next_rdata;

	// Byte lane mask from the four enables
	function automatic logic [31:0] lane_mask(input logic [3:0] be);
		lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction : lane_mask

	// Strobe aimed at one register offset
	function automatic logic hit(input logic strobe,
		input logic [7:0] addr, input logic [7:0] off);
		hit = strobe && (addr == off);
	endfunction : hit

	// Reset leaves through two flops so every flop leaves it together;
	// assertion stays asynchronous so a stopped clock still resets
	lssr_sync #(
		.WIDTH   (1)
	) rst_sync (
		.i_clock (i_clock),
		.i_rst_n (i_rst_n),
		.i_async (1'b1),
		.o_sync  (rst_n)
	);

	// Write and preload decode; upstream ports decode no slot offset
	assign wr_link  = hit(i_cfg_wr, i_cfg_addr, `LSSR_OFF_LINK);
	assign wr_slot  = DOWNSTREAM
		&& hit(i_cfg_wr, i_cfg_addr, `LSSR_OFF_SLOT);
	assign pre_link = hit(i_pre_wr, i_pre_addr, `LSSR_OFF_LINK);
	assign pre_slot = DOWNSTREAM
		&& hit(i_pre_wr, i_pre_addr, `LSSR_OFF_SLOT);
	// Power value starts at bit 7, so byte lane 0 reaches it too
	assign pwr_touch = wr_slot && (|i_cfg_be[2:0]);
	// Byte lanes of the current write
	assign wr_mask = lane_mask(i_cfg_be);
	// Write-one-to-clear strobes need the top byte lane
	assign bw_clr = wr_link && i_cfg_be[3] && i_cfg_wdata[`LSSR_BWM_BIT];
	assign ab_clr = wr_link && i_cfg_be[3] && i_cfg_wdata[`LSSR_ABW_BIT];

	// Negotiated speed, held until a new result is reported
	// A retrain that has not reported yet keeps the old code
	always_ff @(posedge i_clock or negedge rst_n)
	begin
		if (!rst_n)
			speed <= `LSSR_SPEED_5G0;
		else if (i_speed_valid)
			speed <= i_link_gen2 ? `LSSR_SPEED_5G0 : `LSSR_SPEED_2G5;
	end

	// Lane count captured on successful training
	// Width only means something once training has reached L0
	always_ff @(posedge i_clock or negedge rst_n)
	begin
		if (!rst_n)
			width <= `LSSR_WIDTH_RESET;
		else if (i_train_done)
			width <= i_link_width;
	end

	// Training error: failure sets, later success clears; failure wins
	// A failed retrain must never be hidden by a same-cycle success
	always_ff @(posedge i_clock or negedge rst_n)
	begin
		if (!rst_n)
			train_err <= 1'b0;
		else if (i_train_fail)
			train_err <= 1'b1;
		else if (i_train_done)
			train_err <= 1'b0;
	end

	// Training in progress flag; a restart wins over completion
	// Start outranks done so a back-to-back retrain is not lost
	always_ff @(posedge i_clock or negedge rst_n)
	begin
		if (!rst_n)
			training <= 1'b1;
		else if (i_train_start)
			training <= 1'b1;
		else if (i_train_done || i_train_fail)
			training <= 1'b0;
	end

	// Link layer active mirror, one cycle behind the state machine
	// The extra cycle keeps the read path free of the raw input
	always_ff @(posedge i_clock or negedge rst_n)
	begin
		if (!rst_n)
			dl_act <= 1'b0;
		else
			dl_act <= i_dl_active;
	end

	// Bandwidth management status; a hardware set beats a clear
	always_ff @(posedge i_clock or negedge rst_n)
	begin
		if (!rst_n)
			bw_mgmt <= 1'b0;
		else if (i_bw_mgmt_event)
			bw_mgmt <= 1'b1;
		else if (bw_clr)
			bw_mgmt <= 1'b0;
	end

	// Autonomous bandwidth status, same set-over-clear priority
	always_ff @(posedge i_clock or negedge rst_n)
	begin
		if (!rst_n)
			auto_bw <= 1'b0;
		else if (i_auto_bw_event)
			auto_bw <= 1'b1;
		else if (ab_clr)
			auto_bw <= 1'b0;
	end

	// Slot clock bit, software read-only, preload may replace it
	always_ff @(posedge i_clock or negedge rst_n)
	begin
		if (!rst_n)
			slot_clk <= `LSSR_SLOT_CLK_RESET;
		else if (pre_link)
			slot_clk <= i_pre_data[28];
	end

	// Read-only capability flags, replaced only by the preload agent
	always_ff @(posedge i_clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			present  <= `LSSR_PRESENT_RESET;
			surprise <= `LSSR_SURPRISE_RESET;
			hp_cap   <= `LSSR_HP_CAP_RESET;
		end
		else if (pre_slot)
		begin
			present  <= i_pre_data[4:0];
			surprise <= i_pre_data[5];
			hp_cap   <= i_pre_data[6];
		end
	end

	// Slot number follows the board wiring, so only preload sets it
	always_ff @(posedge i_clock or negedge rst_n)
	begin
		if (!rst_n)
			slot_num <= `LSSR_SLOT_NUM_RESET;
		else if (pre_slot)
			slot_num <= i_pre_data[31:19];
	end

	// Power limit value and scale, byte-lane writable; software beats preload
	always_ff @(posedge i_clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pwr_val <= `LSSR_PWR_VAL_RESET;
			pwr_scl <= `LSSR_PWR_SCL_RESET;
		end
		else if (wr_slot)
		begin
			pwr_val <= (pwr_val & ~wr_mask[14:7])
				| (i_cfg_wdata[14:7] & wr_mask[14:7]);
			pwr_scl <= (pwr_scl & ~wr_mask[16:15])
				| (i_cfg_wdata[16:15] & wr_mask[16:15]);
		end
		else if (pre_slot)
		begin
			pwr_val <= i_pre_data[`LSSR_PWR_VAL_MSB:`LSSR_PWR_VAL_LSB];
			pwr_scl <= i_pre_data[`LSSR_PWR_SCL_MSB:`LSSR_PWR_SCL_LSB];
		end
	end

	// Message request one cycle after the write, carrying the new values
	// A write that reaches only the slot number byte sends nothing
	always_ff @(posedge i_clock or negedge rst_n)
	begin
		if (!rst_n)
			o_spl_msg <= 1'b0;
		else
			o_spl_msg <= pwr_touch;
	end

	// The message fields follow the stored limit so they are never stale
	assign o_spl_value = pwr_val;
	assign o_spl_scale = pwr_scl;

	// Read mux; link control half and unmapped offsets read zero
	// Slot word reads zero on upstream ports, which have no slot
	always_comb
	begin
		next_rdata = '0;
		case (i_cfg_addr)
			`LSSR_OFF_LINK:
				next_rdata = {auto_bw, bw_mgmt, dl_act, slot_clk,
					training, train_err, width, speed, 16'h0000};
			`LSSR_OFF_SLOT:
				if (DOWNSTREAM)
					next_rdata = {slot_num, 2'h0, pwr_scl, pwr_val,
						hp_cap, surprise, present};
			default:
				next_rdata = '0;
		endcase
	end

	// Read data registered one cycle after the strobe, zero otherwise
	always_ff @(posedge i_clock or negedge rst_n)
	begin
		if (!rst_n)
			o_cfg_rdata <= '0;
		else
			o_cfg_rdata <= i_cfg_rd ? next_rdata : 32'h0000_0000;
	end

	// Acknowledge one cycle after any configuration read or write strobe; preload writes get none
	always_ff @(posedge i_clock or negedge rst_n)
	begin
		if (!rst_n)
			o_cfg_ack <= 1'b0;
		else
			o_cfg_ack <= i_cfg_rd || i_cfg_wr;
	end
endmodule : lssr_regs

// file: lssr_regs_monitor.sv
// Port-level checks of the link/slot report register bank
`timescale 1ns/1ns
module lssr_mon
	import lssr_pkg::*;
#(
	parameter bit DOWNSTREAM = 1'b1
) (
	// Clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_rst_n,
	// Configuration access
	input  wire logic        i_cfg_rd,
	input  wire logic        i_cfg_wr,
	input  wire logic [7:0]  i_cfg_addr,
	input  wire logic [3:0]  i_cfg_be,
	input  wire logic [31:0] i_cfg_wdata,
	input  wire logic [31:0] o_cfg_rdata,
	input  wire logic        o_cfg_ack,
	// Link state and preload
	input  wire logic        i_dl_active,
	input  wire logic        i_pre_wr,
	// Slot power message
	input  wire logic        o_spl_msg,
	input  wire logic [7:0]  o_spl_value,
	input  wire logic [1:0]  o_spl_scale
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	// Upstream ports have no power fields, so their writes are left out
	wire logic pw = DOWNSTREAM && i_cfg_wr && i_cfg_addr == 8'hd4;
	AST_ACK: assert property ((i_cfg_rd || i_cfg_wr) |=> o_cfg_ack)
		else $error("ack missing after request");
	AST_ACK_NONE: assert property (!(i_cfg_rd || i_cfg_wr) |=> !o_cfg_ack)
		else $error("ack without request");
	AST_RD_IDLE: assert property (!i_cfg_rd |=> o_cfg_rdata == 32'h0)
		else $error("read data not zero outside a read");
	AST_MSG: assert property (pw && i_cfg_be[2:0] != 3'h0 |=> o_spl_msg)
		else $error("power message missing");
	AST_MSG_NONE: assert property (!i_cfg_wr |=> !o_spl_msg)
		else $error("power message without write");
	AST_VAL: assert property (pw && i_cfg_be[1:0] == 2'h3 |=>
		o_spl_value == $past(i_cfg_wdata[14:7]))
		else $error("power value not written");
	AST_SCL: assert property (pw && i_cfg_be[2:1] == 2'h3 |=>
		o_spl_scale == $past(i_cfg_wdata[16:15]))
		else $error("power scale not written");
	AST_HOLD: assert property (!i_cfg_wr && !i_pre_wr |=>
		$stable(o_spl_value) && $stable(o_spl_scale))
		else $error("power fields moved without write");
	AST_DLA: assert property (i_cfg_rd && i_cfg_addr == 8'hd0 &&
		$stable(i_dl_active) |=> o_cfg_rdata[29] == $past(i_dl_active))
		else $error("link active bit wrong");
endmodule : lssr_mon
bind lssr_regs lssr_mon #(.DOWNSTREAM(DOWNSTREAM)) mon (.*);

// file: lssr_sync.sv
// Two-flop synchroniser for a bus of level inputs
`timescale 1ns/1ns
module lssr_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             i_clock,
	input  wire logic             i_rst_n,
	// Data
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] stage1;

	// First stage feeds only the second
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			stage1 <= '0;
			o_sync <= '0;
		end
		else
		begin
			stage1 <= i_async;
			o_sync <= stage1;
		end
	end
endmodule : lssr_sync

// file: tb.sv
// Directed testbench of the link/slot report register bank
`timescale 1ns/1ns
module tb;
	logic        i_clock, i_rst_n, i_cfg_rd, i_cfg_wr, i_pre_wr, i_dl_active;
	logic        i_link_gen2, i_speed_valid, i_train_done, i_train_start;
	logic        i_train_fail, i_bw_mgmt_event, i_auto_bw_event;
	logic        o_cfg_ack, o_spl_msg, up_m;
	logic [7:0]  i_cfg_addr, i_pre_addr, o_spl_value;
	logic [3:0]  i_cfg_be;
	logic [5:0]  i_link_width, evs;
	logic [1:0]  o_spl_scale;
	logic [31:0] i_cfg_wdata, i_pre_data, o_cfg_rdata, up_r;
	int          err_total, num_checks;
	// Event pulses share one vector to keep the drivers short
	assign {i_speed_valid, i_train_done, i_train_start, i_train_fail,
		i_bw_mgmt_event, i_auto_bw_event} = evs;
	lssr_regs uut (.*);
	// Upstream copy: slot word must stay absent
	lssr_regs #(.DOWNSTREAM(1'b0)) up (.*, .o_cfg_rdata(up_r),
		.o_cfg_ack(), .o_spl_msg(up_m), .o_spl_value(), .o_spl_scale());
	initial
	begin
		i_clock = 1'b0;
		forever #5 i_clock = ~i_clock;
	end
	task chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e)
		begin
			err_total++;
			$display("Error %0t: saw %h expected %h", $time, s, e);
		end
	endtask : chk
	// Link word from speed, width and flags {ab,bw,dl,clk,trn,err}
	function logic [31:0] lw(input logic [3:0] s, input logic [5:0] w,
		input logic [5:0] f);
		return {f, w, s, 16'h0};
	endfunction : lw
	task rd(input logic [7:0] a, input logic [31:0] e);
		@(negedge i_clock) {i_cfg_rd, i_cfg_addr} = {1'b1, a};
		@(negedge i_clock) i_cfg_rd = 1'b0;
		chk(o_cfg_ack, 1);
		chk(o_cfg_rdata, e);
		if (a == 8'hd4) chk(up_r, 0);
	endtask : rd
	task wr(input logic [7:0] a, input logic [3:0] b,
		input logic [31:0] d, input logic m);
		@(negedge i_clock) {i_cfg_wr, i_cfg_addr, i_cfg_be} = {1'b1, a, b};
		i_cfg_wdata = d;
		@(negedge i_clock) i_cfg_wr = 1'b0;
		chk(o_spl_msg, m);
		chk(o_cfg_ack, 1);
		chk(up_m, 0);
	endtask : wr
	task ev(input logic [5:0] v);
		@(negedge i_clock) evs = v;
		@(negedge i_clock) evs = 6'h0;
	endtask : ev
	task pre(input logic [7:0] a, input logic [31:0] d);
		@(negedge i_clock) {i_pre_wr, i_pre_addr, i_pre_data} = {1'b1, a, d};
		@(negedge i_clock) i_pre_wr = 1'b0;
	endtask : pre
	task end_of_test;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_of_test
	initial
	begin
		{i_rst_n, i_cfg_rd, i_cfg_wr, i_pre_wr, i_dl_active, i_link_gen2} = 0;
		{i_cfg_addr, i_pre_addr, i_cfg_be, i_cfg_wdata, i_pre_data} = 0;
		{evs, err_total, num_checks} = 0;
		i_link_width = 6'h04;
		repeat (16) @(negedge i_clock);
		i_rst_n = 1'b1;
		repeat (3) @(negedge i_clock);
		// Reset values and an unmapped offset
		rd(8'hd0, lw(4'h2, 6'h01, 6'b000110));
		rd(8'hd4, 32'h0000_0cdf);
		chk(o_spl_value, 8'h19);
		chk(o_spl_scale, 2'h0);
		wr(8'h10, 4'hf, 32'hffff_ffff, 1'b0);
		rd(8'h10, 32'h0);
		$display("test reset done");
		// Training sequence, link layer state and status clears
		ev(6'b100000);
		ev(6'b010000);
		rd(8'hd0, lw(4'h1, 6'h04, 6'b000100));
		ev(6'b000100);
		rd(8'hd0, lw(4'h1, 6'h04, 6'b000101));
		ev(6'b001000);
		rd(8'hd0, lw(4'h1, 6'h04, 6'b000111));
		i_link_width = 6'h02;
		ev(6'b010000);
		rd(8'hd0, lw(4'h1, 6'h02, 6'b000100));
		i_dl_active = 1'b1;
		ev(6'b000011);
		rd(8'hd0, lw(4'h1, 6'h02, 6'b111100));
		wr(8'hd0, 4'hf, 32'h8fff_0000, 1'b0);
		rd(8'hd0, lw(4'h1, 6'h02, 6'b011100));
		wr(8'hd0, 4'h7, 32'h4000_0000, 1'b0);
		rd(8'hd0, lw(4'h1, 6'h02, 6'b011100));
		wr(8'hd0, 4'h8, 32'h4000_0000, 1'b0);
		i_dl_active = 1'b0;
		rd(8'hd0, lw(4'h1, 6'h02, 6'b000100));
		$display("test link done");
		// Slot word: writable power fields, read-only rest, preload
		wr(8'hd4, 4'hf, 32'hffff_ffff, 1'b1);
		rd(8'hd4, 32'h0001_ffdf);
		chk(o_spl_value, 8'hff);
		chk(o_spl_scale, 2'h3);
		wr(8'hd4, 4'h1, 32'h0, 1'b1);
		wr(8'hd4, 4'h8, 32'h0, 1'b0);
		rd(8'hd4, 32'h0001_ff5f);
		pre(8'hd4, 32'h0008_0021);
		rd(8'hd4, 32'h0008_0021);
		pre(8'hd0, 32'h0);
		rd(8'hd0, lw(4'h1, 6'h02, 6'b000000));
		i_link_gen2 = 1'b1;
		ev(6'b100000);
		rd(8'hd0, lw(4'h2, 6'h02, 6'b000000));
		$display("test slot done");
		end_of_test();
	end
endmodule : tb
